// [design/serial_config_port_consts.svh]
`ifndef SERIAL_CONFIG_PORT_CONSTS_SVH
`define SERIAL_CONFIG_PORT_CONSTS_SVH

`define INSTR_BITS       16
`define ADDR_TOP         10'h232
`define CFG_ADDR         10'h000
`define RBSEL_ADDR       10'h004
`define UPD_ADDR         10'h232
`define CFG_RESET        8'h18
`define CFG_UNI_BIT      0
`define CFG_LSB_BIT      1
`define CFG_LSB_MIR_BIT  6
`define RBSEL_BIT        0
`define UPD_BIT          0
`define INSTR_RW_BIT     15
`define INSTR_LEN_MSB    14
`define INSTR_LEN_LSB    13
`define LEN_STREAM       2'h3

`define MCLK_PERIOD_NS   25
`define SCLK_PERIOD_NS   400
`define SCLK_HALF_CYC    ((`SCLK_PERIOD_NS / `MCLK_PERIOD_NS) / 2)

`define HOST_CTRL_OFF    8'h00
`define HOST_TX_OFF      8'h04
`define HOST_RX_OFF      8'h08
`define HOST_STAT_OFF    8'h0c
`define CTRL_LSB_BIT     16
`define CTRL_UNI_BIT     17
`define CTRL_SCNT_LSB    18
`define STAT_BUSY_BIT    0
`define STAT_DONE_BIT    1

`endif

// [design/serial_config_port_pkg.sv]
package serial_config_port_pkg;

   typedef enum logic [1:0]
   {
      DEV_IDLE  = 2'h0,
      DEV_INSTR = 2'h1,
      DEV_DATA  = 2'h3,
      DEV_DONE  = 2'h2
   } dev_state_t;

   typedef enum logic [2:0]
   {
      HOST_IDLE = 3'h0,
      HOST_LEAD = 3'h1,
      HOST_LOW  = 3'h3,
      HOST_HIGH = 3'h2,
      HOST_TAIL = 3'h6
   } host_state_t;

endpackage

// [design/spi_cfg_if.sv]
`timescale 1ns/1ps
interface spi_cfg_if;
   logic cs_n;
   logic sclk;
   logic host_sdio_out;
   logic host_sdio_oe;
   logic dev_sdio_out;
   logic dev_sdio_oe;
   logic dev_sdo_out;
   logic dev_sdo_oe;
   logic sdio;
   logic serial_readback_out_pin;

   // Released wires read low, as with a pull-down
   assign sdio = dev_sdio_oe ? dev_sdio_out : (host_sdio_oe ? host_sdio_out : 1'b0);
   assign serial_readback_out_pin  = dev_sdo_oe ? dev_sdo_out : 1'b0;

   modport dev
   (
      input  cs_n,
      input  sclk,
      input  sdio,
      output dev_sdio_out,
      output dev_sdio_oe,
      output dev_sdo_out,
      output dev_sdo_oe
   );

   modport host
   (
      output cs_n,
      output sclk,
      output host_sdio_out,
      output host_sdio_oe,
      input  sdio,
      input  serial_readback_out_pin
   );
endinterface

// [design/serial_config_port.sv]
`timescale 1ns/1ps
`include "serial_config_port_consts.svh"
module serial_config_port
#(
   parameter int ADDR_W = 10
)
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   spi_cfg_if.dev           link,
   input  wire logic [9:0]  act_addr,
   output logic      [7:0]  act_data,
   output logic             update_pulse
);
   // Address decode is sized for the ten meaningful address bits
   if (ADDR_W != 10)
   begin
      $error("serial_config_port: address width must be 10");
   end

   serial_config_port_pkg::dev_state_t state_ff;

   logic [2:0]  cs_sy_ff;
   logic [2:0]  sclk_sy_ff;
   logic [1:0]  sdio_sy_ff;
   logic [3:0]  cnt_ff;
   logic [15:0] instr_ff;
   logic [9:0]  addr_ff;
   logic [1:0]  nbyte_ff;
   logic [7:0]  wbyte_ff;
   logic [7:0]  rd_byte_ff;
   logic        wr_ff;
   logic [1:0]  len_ff;
   logic [7:0]  cfg_ff;
   logic        upd_ff;
   logic        out_ff;
   logic        oe_ff;
   logic [7:0]  act_data_ff;
   logic [7:0]  shadow [0:`ADDR_TOP];
   logic [7:0]  active [0:`ADDR_TOP];

   logic        cs_low;
   logic        cs_rise;
   logic        rise;
   logic        fall;
   logic        lsb_first;
   logic        stream;
   logic [15:0] nxt_instr;
   logic [7:0]  nxt_wbyte;
   logic        byte_done;
   logic        instr_done;
   logic [9:0]  nxt_addr;
   logic [9:0]  ld_addr;
   logic        drive;

   function automatic logic [15:0] shift16(input logic [15:0] w, input logic b, input logic lsb);
      shift16 = lsb ? {b, w[15:1]} : {w[14:0], b};
   endfunction

   function automatic logic [7:0] shift8(input logic [7:0] w, input logic b, input logic lsb);
      shift8 = lsb ? {b, w[7:1]} : {w[6:0], b};
   endfunction

   // Ascending holds at the update address and descending wraps from 0 onto it, so a stream always ends there
   function automatic logic [9:0] step(input logic [9:0] a, input logic lsb);
      if (lsb)
         step = (a == `ADDR_TOP) ? `ADDR_TOP : a + 10'h001;
      else
         step = (a == `CFG_ADDR) ? `ADDR_TOP : a - 10'h001;
   endfunction

   function automatic logic [7:0] readback(input logic [9:0] a);
      if (a > `ADDR_TOP || a == `UPD_ADDR)
         readback = 8'h00;
      else if (a == `CFG_ADDR)
         readback = cfg_ff;
      else if (active[`RBSEL_ADDR][`RBSEL_BIT])
         readback = active[a];
      else
         readback = shadow[a];
   endfunction

   // Pins come from another domain; first stage feeds only the second
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         cs_sy_ff   <= 3'h7;
         sclk_sy_ff <= 3'h0;
         sdio_sy_ff <= 2'h0;
      end
      else
      begin
         cs_sy_ff   <= {cs_sy_ff[1:0], link.cs_n};
         sclk_sy_ff <= {sclk_sy_ff[1:0], link.sclk};
         sdio_sy_ff <= {sdio_sy_ff[0], link.sdio};
      end
   end

   assign cs_low     = ~cs_sy_ff[1];
   assign cs_rise    = cs_sy_ff[1] & ~cs_sy_ff[2];
   assign rise       = cs_low & sclk_sy_ff[1] & ~sclk_sy_ff[2];
   assign fall       = cs_low & ~sclk_sy_ff[1] & sclk_sy_ff[2];
   assign lsb_first  = cfg_ff[`CFG_LSB_BIT] | cfg_ff[`CFG_LSB_MIR_BIT];
   assign stream     = (len_ff == `LEN_STREAM);
   assign nxt_instr  = shift16(instr_ff, sdio_sy_ff[1], lsb_first);
   assign nxt_wbyte  = shift8(wbyte_ff, sdio_sy_ff[1], lsb_first);
   assign instr_done = rise && state_ff == serial_config_port_pkg::DEV_INSTR && cnt_ff == 4'hf;
   assign byte_done  = rise && state_ff == serial_config_port_pkg::DEV_DATA && cnt_ff[2:0] == 3'h7;
   assign nxt_addr   = step(addr_ff, lsb_first);
   assign ld_addr    = instr_done ? nxt_instr[9:0] : nxt_addr;
   assign drive      = cs_low && !wr_ff && state_ff == serial_config_port_pkg::DEV_DATA;

   // Transfer sequencing
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state_ff <= serial_config_port_pkg::DEV_IDLE;
         cnt_ff   <= 4'h0;
         instr_ff <= 16'h0000;
         addr_ff  <= 10'h000;
         nbyte_ff <= 2'h0;
         wbyte_ff <= 8'h00;
         wr_ff    <= 1'b0;
         len_ff   <= 2'h0;
      end
      else if (cs_rise && (cnt_ff[2:0] != 3'h0 || state_ff == serial_config_port_pkg::DEV_DONE
                           || (state_ff == serial_config_port_pkg::DEV_DATA && stream)))
      begin
         state_ff <= serial_config_port_pkg::DEV_IDLE;
         cnt_ff   <= 4'h0;
      end
      else if (rise)
      begin
         unique case (state_ff)
            serial_config_port_pkg::DEV_IDLE:
            begin
               instr_ff <= nxt_instr;
               cnt_ff   <= 4'h1;
               state_ff <= serial_config_port_pkg::DEV_INSTR;
            end
            serial_config_port_pkg::DEV_INSTR:
            begin
               instr_ff <= nxt_instr;
               cnt_ff   <= cnt_ff + 4'h1;
               if (cnt_ff == 4'hf)
               begin
                  state_ff <= serial_config_port_pkg::DEV_DATA;
                  wr_ff    <= ~nxt_instr[`INSTR_RW_BIT];
                  len_ff   <= nxt_instr[`INSTR_LEN_MSB:`INSTR_LEN_LSB];
                  addr_ff  <= nxt_instr[9:0];
                  nbyte_ff <= 2'h0;
               end
            end
            serial_config_port_pkg::DEV_DATA:
            begin
               wbyte_ff <= nxt_wbyte;
               cnt_ff   <= {1'b0, cnt_ff[2:0] + 3'h1};
               if (cnt_ff[2:0] == 3'h7)
               begin
                  nbyte_ff <= nbyte_ff + 2'h1;
                  addr_ff  <= nxt_addr;
                  if ((!stream && nbyte_ff == len_ff) || (stream && addr_ff == `ADDR_TOP))
                     state_ff <= serial_config_port_pkg::DEV_DONE;
               end
            end
            serial_config_port_pkg::DEV_DONE:
               cnt_ff <= 4'h0;
         endcase
      end
   end

   // Buffer writes; config, update and over-range addresses drop the data
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i <= `ADDR_TOP; i++)
            shadow[i] <= 8'h00;
      end
      else if (byte_done && wr_ff && addr_ff <= `ADDR_TOP && addr_ff != `CFG_ADDR && addr_ff != `UPD_ADDR)
         shadow[addr_ff] <= nxt_wbyte;
   end

   // Port config bypasses the buffer so bit order changes at once
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         cfg_ff <= `CFG_RESET;
      else if (byte_done && wr_ff && addr_ff == `CFG_ADDR)
         cfg_ff <= nxt_wbyte;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         upd_ff <= 1'b0;
      else
         upd_ff <= byte_done && wr_ff && addr_ff == `UPD_ADDR && nxt_wbyte[`UPD_BIT];
   end

   // Whole buffer moves in one edge; costly but keeps changes simultaneous
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         for (int i = 0; i <= `ADDR_TOP; i++)
            active[i] <= 8'h00;
      end
      else if (upd_ff)
      begin
         for (int i = 0; i <= `ADDR_TOP; i++)
            active[i] <= shadow[i];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         rd_byte_ff <= 8'h00;
      else if (instr_done || byte_done)
         rd_byte_ff <= readback(ld_addr);
   end

   // Drive starts at a fall, after the host has let go of the shared pin
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         out_ff <= 1'b0;
         oe_ff  <= 1'b0;
      end
      else if (!drive)
         oe_ff <= 1'b0;
      else if (fall)
      begin
         oe_ff  <= 1'b1;
         out_ff <= lsb_first ? rd_byte_ff[cnt_ff[2:0]] : rd_byte_ff[3'h7 - cnt_ff[2:0]];
      end
   end

   assign link.dev_sdio_out = out_ff;
   assign link.dev_sdo_out  = out_ff;
   assign link.dev_sdio_oe  = oe_ff & ~cfg_ff[`CFG_UNI_BIT];
   assign link.dev_sdo_oe   = oe_ff & cfg_ff[`CFG_UNI_BIT];

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         act_data_ff <= 8'h00;
      else
         act_data_ff <= (act_addr <= `ADDR_TOP) ? active[act_addr] : 8'h00;
   end

   assign act_data     = act_data_ff;
   assign update_pulse = upd_ff;
endmodule

// [design/serial_config_host.sv]
`timescale 1ns/1ps
`include "serial_config_port_consts.svh"
module serial_config_host
#(
   parameter int HALF = `SCLK_HALF_CYC
)
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   spi_cfg_if.host          link
);
   // Device needs a few mclk per phase to sync and launch
   if (HALF < 8 || HALF > 255)
   begin
      $error("serial_config_host: HALF must lie in 8..255");
   end

   serial_config_port_pkg::host_state_t state_ff;

   logic [19:0] ctrl_ff;
   logic [31:0] tx_ff;
   logic [31:0] rx_ff;
   logic        done_ff;
   logic [31:0] prdata_ff;
   logic [7:0]  div_ff;
   logic [5:0]  bit_ff;
   logic [5:0]  total_ff;
   logic        cs_n_ff;
   logic        sclk_ff;
   logic        mosi_ff;
   logic        moe_ff;
   logic [1:0]  sdio_sy_ff;
   logic [1:0]  sdo_sy_ff;

   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic        start;
   logic        tick;
   logic        busy;
   logic        lsb;
   logic        is_read;
   logic [5:0]  nxt_bit;
   logic [5:0]  didx;
   logic [1:0]  nbytes_m1;

   function automatic logic [4:0] pos(input logic [5:0] d, input logic l);
      pos = {d[4:3], l ? d[2:0] : 3'h7 - d[2:0]};
   endfunction

   function automatic logic bit_val(input logic [5:0] k);
      logic [5:0] d;
      d = k - 6'd16;
      if (k < 6'd16)
         bit_val = lsb ? ctrl_ff[k[3:0]] : ctrl_ff[4'hf - k[3:0]];
      else
         bit_val = tx_ff[pos(d, lsb)];
   endfunction

   assign busy      = state_ff != serial_config_port_pkg::HOST_IDLE;
   assign lsb       = ctrl_ff[`CTRL_LSB_BIT];
   assign is_read   = ctrl_ff[`INSTR_RW_BIT];
   assign wr_acc    = psel & penable & pwrite;
   assign rd_setup  = psel & ~penable & ~pwrite;
   assign mapped    = paddr == `HOST_CTRL_OFF || paddr == `HOST_TX_OFF
                      || paddr == `HOST_RX_OFF || paddr == `HOST_STAT_OFF;
   assign start     = wr_acc && paddr == `HOST_CTRL_OFF && !busy;
   assign tick      = div_ff == 8'(HALF - 1);
   assign nxt_bit   = bit_ff + 6'h1;
   assign didx      = bit_ff - 6'd16;
   // Streaming transfers are cut to the transmit word: 1..4 bytes
   assign nbytes_m1 = (pwdata[`INSTR_LEN_MSB:`INSTR_LEN_LSB] == `LEN_STREAM)
                      ? pwdata[`CTRL_SCNT_LSB +: 2] : pwdata[`INSTR_LEN_MSB:`INSTR_LEN_LSB];

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         ctrl_ff <= 20'h00000;
         tx_ff   <= 32'h00000000;
      end
      else if (wr_acc && paddr == `HOST_TX_OFF && !busy)
         tx_ff <= pwdata;
      else if (start)
         ctrl_ff <= {pwdata[19:13], 3'h0, pwdata[9:0]};
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
         prdata_ff <= 32'h00000000;
      else if (rd_setup)
      begin
         unique case (paddr)
            `HOST_CTRL_OFF: prdata_ff <= {12'h000, ctrl_ff};
            `HOST_TX_OFF:   prdata_ff <= tx_ff;
            `HOST_RX_OFF:   prdata_ff <= rx_ff;
            `HOST_STAT_OFF: prdata_ff <= {30'h0, done_ff, busy};
            default:        prdata_ff <= 32'h00000000;
         endcase
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;

   // Finish sets done even when software clears it in the same edge
   always_ff @(posedge mclk)
   begin
      if (!resetn)
         done_ff <= 1'b0;
      else if (state_ff == serial_config_port_pkg::HOST_TAIL && tick)
         done_ff <= 1'b1;
      else if (start || (wr_acc && paddr == `HOST_STAT_OFF && pwdata[`STAT_DONE_BIT]))
         done_ff <= 1'b0;
   end

   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         sdio_sy_ff <= 2'h0;
         sdo_sy_ff  <= 2'h0;
      end
      else
      begin
         sdio_sy_ff <= {sdio_sy_ff[0], link.sdio};
         sdo_sy_ff  <= {sdo_sy_ff[0], link.serial_readback_out_pin};
      end
   end

   // Serial clock made here by dividing mclk
   always_ff @(posedge mclk)
   begin
      if (!resetn)
      begin
         state_ff <= serial_config_port_pkg::HOST_IDLE;
         div_ff   <= 8'h00;
         bit_ff   <= 6'h00;
         total_ff <= 6'h00;
         cs_n_ff  <= 1'b1;
         sclk_ff  <= 1'b0;
         mosi_ff  <= 1'b0;
         moe_ff   <= 1'b0;
         rx_ff    <= 32'h00000000;
      end
      else
      begin
         div_ff <= (tick || state_ff == serial_config_port_pkg::HOST_IDLE) ? 8'h00 : div_ff + 8'h01;
         unique case (state_ff)
            serial_config_port_pkg::HOST_IDLE:
               if (start)
               begin
                  state_ff <= serial_config_port_pkg::HOST_LEAD;
                  cs_n_ff  <= 1'b0;
                  bit_ff   <= 6'h00;
                  total_ff <= 6'd24 + {1'b0, nbytes_m1, 3'h0};
                  rx_ff    <= 32'h00000000;
               end
            serial_config_port_pkg::HOST_LEAD:
               if (tick)
               begin
                  state_ff <= serial_config_port_pkg::HOST_LOW;
                  mosi_ff  <= bit_val(6'h00);
                  moe_ff   <= 1'b1;
               end
            serial_config_port_pkg::HOST_LOW:
               if (tick)
               begin
                  state_ff <= serial_config_port_pkg::HOST_HIGH;
                  sclk_ff  <= 1'b1;
                  if (bit_ff >= 6'd16 && is_read)
                     rx_ff[pos(didx, lsb)] <= ctrl_ff[`CTRL_UNI_BIT] ? sdo_sy_ff[1] : sdio_sy_ff[1];
               end
            serial_config_port_pkg::HOST_HIGH:
               if (tick)
               begin
                  sclk_ff <= 1'b0;
                  bit_ff  <= nxt_bit;
                  if (nxt_bit == total_ff)
                  begin
                     state_ff <= serial_config_port_pkg::HOST_TAIL;
                     moe_ff   <= 1'b0;
                  end
                  else
                  begin
                     state_ff <= serial_config_port_pkg::HOST_LOW;
                     mosi_ff  <= bit_val(nxt_bit);
                     moe_ff   <= (nxt_bit < 6'd16) || !is_read;
                  end
               end
            serial_config_port_pkg::HOST_TAIL:
               if (tick)
               begin
                  state_ff <= serial_config_port_pkg::HOST_IDLE;
                  cs_n_ff  <= 1'b1;
               end
            default:
               state_ff <= serial_config_port_pkg::HOST_IDLE;
         endcase
      end
   end

   assign link.cs_n          = cs_n_ff;
   assign link.sclk          = sclk_ff;
   assign link.host_sdio_out = mosi_ff;
   assign link.host_sdio_oe  = moe_ff;
endmodule

// [testbench/serial_config_port_monitor.sv]
`timescale 1ns/1ps
module serial_config_port_monitor
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdio_out,
   input wire logic host_sdio_oe,
   input wire logic dev_sdio_out,
   input wire logic dev_sdio_oe,
   input wire logic dev_sdo_out,
   input wire logic dev_sdo_oe
);
   logic       sclk_d_ff;
   logic [4:0] rise_cnt_ff;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   always_ff @(posedge mclk)
   begin
      sclk_d_ff <= sclk;
   end

   // Saturates so a long stream cannot wrap back to 16
   always_ff @(posedge mclk)
   begin
      if (!resetn || cs_n)
         rise_cnt_ff <= 5'h00;
      else if (sclk && !sclk_d_ff && rise_cnt_ff != 5'h1f)
         rise_cnt_ff <= rise_cnt_ff + 5'h01;
   end

   sequence s_high_half;
      sclk [*8];
   endsequence
   sequence s_dev_starts;
      $rose(dev_sdio_oe) || $rose(dev_sdo_oe);
   endsequence

   property p_released;
      cs_n [*6] |-> !dev_sdio_oe && !dev_sdo_oe;
   endproperty
   property p_no_clash;
      !(dev_sdio_oe && host_sdio_oe);
   endproperty
   property p_one_pin;
      !(dev_sdio_oe && dev_sdo_oe);
   endproperty
   property p_end_low;
      $rose(cs_n) |-> !sclk;
   endproperty
   property p_host_hold;
      sclk && $past(sclk) && host_sdio_oe |-> $stable(host_sdio_out);
   endproperty
   property p_dev_launch;
      (dev_sdio_oe && $past(dev_sdio_oe) && $changed(dev_sdio_out)) ||
      (dev_sdo_oe && $past(dev_sdo_oe) && $changed(dev_sdo_out)) |-> !sclk;
   endproperty
   property p_in_frame;
      s_dev_starts |-> !cs_n;
   endproperty
   property p_instr_first;
      s_dev_starts |-> rise_cnt_ff == 5'h10;
   endproperty
   property p_sclk_half;
      $rose(sclk) |-> s_high_half ##1 !sclk;
   endproperty

   a_released: assert property (p_released) else $error("data pin driven while deselected");
   a_no_clash: assert property (p_no_clash) else $error("both ends drive sdio");
   a_one_pin: assert property (p_one_pin) else $error("readback on both pins");
   a_end_low: assert property (p_end_low) else $error("select rose with clock high");
   a_host_hold: assert property (p_host_hold) else $error("host data moved in high phase");
   a_dev_launch: assert property (p_dev_launch) else $error("readback moved in high phase");
   a_in_frame: assert property (p_in_frame) else $error("readback outside frame");
   a_instr_first: assert property (p_instr_first) else $error("readback not after 16 rises");
   a_sclk_half: assert property (p_sclk_half) else $error("clock high phase length wrong");
endmodule

// [testbench/serial_config_port_test.sv]
`timescale 1ns/1ps
`include "serial_config_port_consts.svh"
module serial_config_port_test;
   logic        mclk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  act_addr;
   logic [7:0]  act_data;
   logic        update_pulse;
   logic [31:0] rdat;
   logic        rerr;
   int          n_mismatch;
   int          num_checks;
   int          n_upd;
   int          cyc;

   spi_cfg_if link();

   serial_config_port u_serial_config_port (.mclk(mclk), .resetn(resetn), .link(link), .act_addr(act_addr),
      .act_data(act_data), .update_pulse(update_pulse));
   serial_config_host u_serial_config_host (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link(link));
   serial_config_port_monitor u_serial_config_port_monitor (.mclk(mclk), .resetn(resetn), .cs_n(link.cs_n),
      .sclk(link.sclk), .host_sdio_out(link.host_sdio_out), .host_sdio_oe(link.host_sdio_oe),
      .dev_sdio_out(link.dev_sdio_out), .dev_sdio_oe(link.dev_sdio_oe), .dev_sdo_out(link.dev_sdo_out),
      .dev_sdo_oe(link.dev_sdo_oe));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   task automatic results();
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Counts update pulses; the bench never sees a pulse any other way
   always @(posedge mclk)
   begin
      cyc <= cyc + 1;
      if (update_pulse === 1'b1)
         n_upd <= n_upd + 1;
      if (cyc == 40000)
      begin
         n_mismatch++;
         results();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [31:0] mk(logic rd, logic [1:0] len, logic [9:0] a, logic lsb, logic uni,
                                      logic [1:0] sc);
      return {12'h000, sc, uni, lsb, rd, len, 3'h0, a};
   endfunction

   // One whole frame; status poll is the only completion signal
   task automatic spi(input logic [31:0] ctrl, input logic [31:0] tx);
      apb(1'b1, `HOST_TX_OFF, tx);
      apb(1'b1, `HOST_CTRL_OFF, ctrl);
      do apb(1'b0, `HOST_STAT_OFF, 32'h0); while (rdat[`STAT_DONE_BIT] !== 1'b1);
      apb(1'b0, `HOST_RX_OFF, 32'h0);
   endtask

   task automatic act(input logic [9:0] a, input logic [7:0] e);
      act_addr <= a;
      repeat (2) @(posedge mclk);
      chk(act_data, e);
   endtask

   initial
   begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      act_addr = 10'h000;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      spi(mk(1'b1, 2'h0, `CFG_ADDR, 1'b0, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'h18);
      spi(mk(1'b0, 2'h1, 10'h011, 1'b0, 1'b0, 2'h0), 32'h3ca5);
      act(10'h011, 8'h00);
      spi(mk(1'b1, 2'h1, 10'h011, 1'b0, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'ha5);
      chk(rdat[15:8], 8'h3c);
      spi(mk(1'b0, 2'h0, `UPD_ADDR, 1'b0, 1'b0, 2'h0), 32'h01);
      spi(mk(1'b1, 2'h0, `UPD_ADDR, 1'b0, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'h00);
      chk(n_upd[7:0], 8'h01);
      act(10'h010, 8'h3c);
      spi(mk(1'b0, 2'h0, `RBSEL_ADDR, 1'b0, 1'b0, 2'h0), 32'h01);
      spi(mk(1'b0, 2'h0, `UPD_ADDR, 1'b0, 1'b0, 2'h0), 32'h01);
      spi(mk(1'b0, 2'h0, 10'h011, 1'b0, 1'b0, 2'h0), 32'h77);
      spi(mk(1'b1, 2'h0, 10'h011, 1'b0, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'ha5);
      // Switch to low-bit-first; host order follows it
      spi(mk(1'b0, 2'h0, `CFG_ADDR, 1'b0, 1'b0, 2'h0), 32'h5a);
      spi(mk(1'b0, `LEN_STREAM, 10'h230, 1'b1, 1'b0, 2'h2), 32'h015544);
      chk(n_upd[7:0], 8'h03);
      act(10'h231, 8'h55);
      act(10'h230, 8'h44);
      spi(mk(1'b1, 2'h1, 10'h011, 1'b1, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'h77);
      chk(rdat[15:8], 8'h00);
      // Four bytes asked; stream stops after the update address, pull-down fills the rest
      spi(mk(1'b1, `LEN_STREAM, 10'h230, 1'b1, 1'b0, 2'h3), 32'h0);
      chk(rdat[7:0], 8'h44);
      chk(rdat[15:8], 8'h55);
      chk(rdat[31:24], 8'h00);
      spi(mk(1'b0, 2'h0, `CFG_ADDR, 1'b1, 1'b0, 2'h0), 32'hdb);
      spi(mk(1'b1, 2'h0, `CFG_ADDR, 1'b1, 1'b1, 2'h0), 32'h0);
      chk(rdat[7:0], 8'hdb);
      act(10'h233, 8'h00);
      // Mid-run reset must bring back default bit order and config
      resetn <= 1'b0;
      repeat (8) @(posedge mclk);
      resetn <= 1'b1;
      spi(mk(1'b1, 2'h0, `CFG_ADDR, 1'b0, 1'b0, 2'h0), 32'h0);
      chk(rdat[7:0], 8'h18);
      apb(1'b0, 8'h10, 32'h0);
      chk({7'h00, rerr}, 8'h01);
      results();
   end
endmodule
